/* thm_pkg.sv */
// constants and types for the thermostat holding-register bank
// ---------------------------------------------------------------------------
// Functional notes
// - function 03 returns a run of holding registers from the start address.
// - function 06 overwrites exactly one holding register with a 16-bit value.
// - function 16 writes consecutive registers; multi-register values need it.
// - function 23 writes then reads registers within one transaction.
// - run control at 40001: 0 standby, 1 unit started.
// - actuation source at 40002: 0 controller, 1 link value, 2 external programmer.
// - control location at 40011: 0 internal bath, 1 external platinum sensor.
// - inner proportional band float at 12-13, range 0.1 to 99.9 K.
// - inner reset time at 14, range 3 to 9999 s.
// - inner derivative time at 15, range 0 to 999 s.
// - cascade band, reset and derivative times at 40018, 40020, 40021 with limits.
// - subordinate proportional share float at 40022, range 0.1 to 99.9 K.
// - cascade speed factor float at 23-24, range 0.0 to 5.0.
// - exception 01 for unsupported function or write outside remote mode.
// - exception 02 for bad address or access splitting a multi-register value.
// - exception 03 and no change when a written value is out of range.
// - floats are IEEE754 words split over two consecutive registers.
// ---------------------------------------------------------------------------
package thm_pkg;

  localparam int NREG = 25;
  typedef logic [NREG-1:0][15:0] thm_bank_t;

  // function and exception codes
  localparam logic [7:0] FC_RD_HOLD   = 8'h03;
  localparam logic [7:0] FC_RD_INPUT  = 8'h04;
  localparam logic [7:0] FC_WR_SINGLE = 8'h06;
  localparam logic [7:0] FC_WR_MULTI  = 8'h10;
  localparam logic [7:0] FC_RD_WR     = 8'h17;
  localparam logic [7:0] EXC_NONE     = 8'h00;
  localparam logic [7:0] EXC_FUNC     = 8'h01;
  localparam logic [7:0] EXC_ADDR     = 8'h02;
  localparam logic [7:0] EXC_VALUE    = 8'h03;

  // protocol addresses (register index)
  localparam int OFS_RUN      = 0;
  localparam int OFS_ACT_SRC  = 1;
  localparam int OFS_SETPOINT = 2;
  localparam int OFS_LINK_ACT = 4;
  localparam int OFS_ACT_TEMP = 5;
  localparam int OFS_GAP_LO   = 8;
  localparam int OFS_GAP_HI   = 9;
  localparam int OFS_CTRL_LOC = 10;
  localparam int OFS_IDENT    = 11;
  localparam int OFS_IN_XP    = 12;
  localparam int OFS_IN_TN    = 14;
  localparam int OFS_IN_TV    = 15;
  localparam int OFS_DYNAMICS = 16;
  localparam int OFS_CA_XP    = 17;
  localparam int OFS_CA_TN    = 19;
  localparam int OFS_CA_TV    = 20;
  localparam int OFS_SUB_XP   = 21;
  localparam int OFS_SPEED    = 23;
  localparam int OFS_LAST     = 24;

  // permitted ranges, floats as IEEE754 bit patterns
  localparam logic [31:0] BAND_MIN   = 32'h3dcc_cccd;
  localparam logic [31:0] BAND_MAX   = 32'h42c7_cccd;
  localparam logic [31:0] SPEED_MAX  = 32'h40a0_0000;
  localparam logic [31:0] SP_MIN     = 32'hc248_0000;
  localparam logic [31:0] SP_MAX     = 32'h4348_0000;
  localparam logic [15:0] TN_MIN     = 16'h0003;
  localparam logic [15:0] TN_MAX     = 16'h270f;
  localparam logic [15:0] TV_MAX     = 16'h03e7;
  localparam logic [15:0] LINK_MIN   = 16'hff9c;
  localparam logic [15:0] LINK_MAX   = 16'h0064;
  localparam logic [15:0] SRC_MAX    = 16'h0002;
  localparam logic [15:0] TSRC_MAX   = 16'h0005;
  localparam logic [15:0] TSRC_PROG  = 16'h0014;
  localparam logic [15:0] FLAG_MAX   = 16'h0001;

  // values after reset, index 24 down to 0
  localparam thm_bank_t REG_RESET = {
    16'h0000, 16'h3f80, 16'h0000, 16'h4040, 16'h0000,
    16'h0064, 16'h0000, 16'h4040, 16'h0000, 16'h0000,
    16'h0064, 16'h0000, 16'h4040, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h41a0, 16'h0000, 16'h0000};

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WRITE = 3'b001,
    ST_CHECK = 3'b010,
    ST_READ  = 3'b011,
    ST_RESP  = 3'b100
  } thm_fsm_t;

endpackage : thm_pkg

/* thm_holding_regs.sv */
// holding-register bank with function-code decode for the thermostat
`timescale 1ns/1ps
module thm_holding_regs (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // remote control mode pin
  input  wire logic        remote_mode_in,
  // request
  input  wire logic        req_valid_in,
  input  wire logic [7:0]  req_func_in,
  input  wire logic [15:0] req_rd_addr_in,
  input  wire logic [7:0]  req_rd_qty_in,
  input  wire logic [15:0] req_wr_addr_in,
  input  wire logic [7:0]  req_wr_qty_in,
  output logic             req_ready_out,
  // write words
  input  wire logic        wr_valid_in,
  input  wire logic [15:0] wr_data_in,
  output logic             wr_ready_out,
  // answer
  output logic             rsp_valid_out,
  output logic [15:0]      rsp_data_out,
  output logic             rsp_last_out,
  output logic [7:0]       rsp_exc_out,
  // settings to the unit
  output logic             unit_run_out,
  output logic [1:0]       actuation_source_out,
  output logic             control_location_out,
  output logic [1:0]       identification_mode_out,
  output logic [31:0]      setpoint_out
);

  typedef struct packed {
    thm_pkg::thm_fsm_t st;
    thm_pkg::thm_bank_t regs;
    thm_pkg::thm_bank_t stage;
    logic [7:0]  func;
    logic [15:0] rd_addr;
    logic [7:0]  rd_qty;
    logic [15:0] ptr;
    logic [7:0]  cnt;
    logic [7:0]  exc;
    logic [1:0]  rem;
    logic        req_ready;
    logic        wr_ready;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic        rsp_last;
    logic [7:0]  rsp_exc;
    logic        unit_run;
    logic [1:0]  act_src;
    logic        ctrl_loc;
    logic [1:0]  ident;
  } thm_core_t;

  thm_core_t s_q;
  thm_core_t s_d;

  // ---------------------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------------------
  // signed float compare a <= b; minus zero counts below plus zero
  function automatic logic f_le(input logic [31:0] a, input logic [31:0] b);
    if (a[31] != b[31]) return a[31];
    else if (!a[31]) return a <= b;
    else return a >= b;
  endfunction : f_le

  // first register of a two-register float
  function automatic logic is_lo(input logic [16:0] a);
    return a == 17'(thm_pkg::OFS_SETPOINT) || a == 17'(thm_pkg::OFS_ACT_TEMP + 1)
        || a == 17'(thm_pkg::OFS_IN_XP) || a == 17'(thm_pkg::OFS_CA_XP)
        || a == 17'(thm_pkg::OFS_SUB_XP) || a == 17'(thm_pkg::OFS_SPEED);
  endfunction : is_lo

  function automatic logic is_hi(input logic [16:0] a);
    return a != 17'h0_0000 && is_lo(a - 17'h0_0001);
  endfunction : is_hi

  // whole span mapped and no float cut in half
  function automatic logic span_ok(input logic [15:0] a, input logic [7:0] q);
    logic [16:0] e;
    e = {1'b0, a} + {9'h000, q} - 17'h0_0001;
    return e <= 17'(thm_pkg::OFS_LAST)
        && !(a <= 16'(thm_pkg::OFS_GAP_HI) && e >= 17'(thm_pkg::OFS_GAP_LO))
        && !is_hi({1'b0, a}) && !is_lo(e);
  endfunction : span_ok

  function automatic logic band_ok(input logic [31:0] f);
    return !f[31] && f >= thm_pkg::BAND_MIN && f <= thm_pkg::BAND_MAX;
  endfunction : band_ok

  function automatic logic time_ok(input logic [15:0] tn, input logic [15:0] tv);
    return tn >= thm_pkg::TN_MIN && tn <= thm_pkg::TN_MAX && tv <= thm_pkg::TV_MAX;
  endfunction : time_ok

  function automatic logic [31:0] fl(input thm_pkg::thm_bank_t r, input int i);
    return {r[i], r[i+1]};
  endfunction : fl

  // whole bank within its permitted ranges
  function automatic logic bank_ok(input thm_pkg::thm_bank_t r);
    logic [31:0] sp;
    sp = fl(r, thm_pkg::OFS_SETPOINT);
    return r[thm_pkg::OFS_RUN] <= thm_pkg::FLAG_MAX
        && r[thm_pkg::OFS_ACT_SRC] <= thm_pkg::SRC_MAX
        && f_le(thm_pkg::SP_MIN, sp) && f_le(sp, thm_pkg::SP_MAX)
        && $signed(r[thm_pkg::OFS_LINK_ACT]) >= $signed(thm_pkg::LINK_MIN)
        && $signed(r[thm_pkg::OFS_LINK_ACT]) <= $signed(thm_pkg::LINK_MAX)
        && (r[thm_pkg::OFS_ACT_TEMP] <= thm_pkg::TSRC_MAX
            || r[thm_pkg::OFS_ACT_TEMP] == thm_pkg::TSRC_PROG)
        && r[thm_pkg::OFS_CTRL_LOC] <= thm_pkg::FLAG_MAX
        && r[thm_pkg::OFS_IDENT] <= thm_pkg::SRC_MAX
        && band_ok(fl(r, thm_pkg::OFS_IN_XP))
        && time_ok(r[thm_pkg::OFS_IN_TN], r[thm_pkg::OFS_IN_TV])
        && r[thm_pkg::OFS_DYNAMICS] <= thm_pkg::FLAG_MAX
        && band_ok(fl(r, thm_pkg::OFS_CA_XP))
        && time_ok(r[thm_pkg::OFS_CA_TN], r[thm_pkg::OFS_CA_TV])
        && band_ok(fl(r, thm_pkg::OFS_SUB_XP))
        && !r[thm_pkg::OFS_SPEED][15]
        && fl(r, thm_pkg::OFS_SPEED) <= thm_pkg::SPEED_MAX;
  endfunction : bank_ok

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  logic        is_wr;
  logic        is_rd;
  logic [7:0]  wqty;
  logic [31:0] sp_clamp;

  always_comb begin
    is_wr = req_func_in == thm_pkg::FC_WR_SINGLE || req_func_in == thm_pkg::FC_WR_MULTI
         || req_func_in == thm_pkg::FC_RD_WR;
    is_rd = req_func_in == thm_pkg::FC_RD_HOLD || req_func_in == thm_pkg::FC_RD_INPUT
         || req_func_in == thm_pkg::FC_RD_WR;
    wqty  = (req_func_in == thm_pkg::FC_WR_SINGLE) ? 8'h01 : req_wr_qty_in;
    sp_clamp = fl(s_q.regs, thm_pkg::OFS_SETPOINT);
    if (f_le(sp_clamp, thm_pkg::SP_MIN)) sp_clamp = thm_pkg::SP_MIN;
    else if (f_le(thm_pkg::SP_MAX, sp_clamp)) sp_clamp = thm_pkg::SP_MAX;
    s_d = s_q;
    s_d.rem = {s_q.rem[0], remote_mode_in};
    s_d.rsp_valid = 1'b0;
    s_d.rsp_last  = 1'b0;
    unique case (s_q.st)
      thm_pkg::ST_IDLE: begin
        if (req_valid_in) begin
          s_d.func    = req_func_in;
          s_d.rd_addr = req_rd_addr_in;
          s_d.rd_qty  = req_rd_qty_in;
          s_d.stage   = s_q.regs;
          s_d.exc     = thm_pkg::EXC_NONE;
          s_d.ptr     = req_wr_addr_in;
          s_d.cnt     = wqty;
          s_d.st      = thm_pkg::ST_RESP;
          if (!is_wr && !is_rd) s_d.exc = thm_pkg::EXC_FUNC;
          else if (is_wr && !s_q.rem[1]) s_d.exc = thm_pkg::EXC_FUNC;
          else if ((is_wr && wqty == 8'h00) || (is_rd && req_rd_qty_in == 8'h00))
            s_d.exc = thm_pkg::EXC_VALUE;
          else if (is_wr && !span_ok(req_wr_addr_in, wqty))
            s_d.exc = thm_pkg::EXC_ADDR;
          else if (req_func_in == thm_pkg::FC_RD_INPUT && !(req_rd_qty_in == 8'h02
                   && req_rd_addr_in == 16'(thm_pkg::OFS_SETPOINT)))
            s_d.exc = thm_pkg::EXC_ADDR;
          else if (req_func_in != thm_pkg::FC_RD_INPUT && is_rd
                   && !span_ok(req_rd_addr_in, req_rd_qty_in))
            s_d.exc = thm_pkg::EXC_ADDR;
          else if (is_wr) s_d.st = thm_pkg::ST_WRITE;
          else begin
            s_d.st  = thm_pkg::ST_READ;
            s_d.ptr = req_rd_addr_in;
            s_d.cnt = req_rd_qty_in;
          end
        end
      end
      thm_pkg::ST_WRITE: begin
        // words land in the stage only; the bank moves as one at check
        if (wr_valid_in) begin
          s_d.stage[s_q.ptr[4:0]] = wr_data_in;
          s_d.ptr = s_q.ptr + 16'h0001;
          s_d.cnt = s_q.cnt - 8'h01;
          if (s_q.cnt == 8'h01) s_d.st = thm_pkg::ST_CHECK;
        end
      end
      thm_pkg::ST_CHECK: begin
        if (bank_ok(s_q.stage)) begin
          s_d.regs = s_q.stage;
          if (s_q.func == thm_pkg::FC_RD_WR) begin
            s_d.st  = thm_pkg::ST_READ;
            s_d.ptr = s_q.rd_addr;
            s_d.cnt = s_q.rd_qty;
          end else s_d.st = thm_pkg::ST_RESP;
        end else begin
          s_d.exc = thm_pkg::EXC_VALUE;
          s_d.st  = thm_pkg::ST_RESP;
        end
      end
      thm_pkg::ST_READ: begin
        s_d.rsp_valid = 1'b1;
        s_d.rsp_exc   = thm_pkg::EXC_NONE;
        s_d.rsp_last  = s_q.cnt == 8'h01;
        if (s_q.func == thm_pkg::FC_RD_INPUT)
          s_d.rsp_data = s_q.ptr[0] ? sp_clamp[15:0] : sp_clamp[31:16];
        else s_d.rsp_data = s_q.regs[s_q.ptr[4:0]];
        s_d.ptr = s_q.ptr + 16'h0001;
        s_d.cnt = s_q.cnt - 8'h01;
        if (s_q.cnt == 8'h01) s_d.st = thm_pkg::ST_IDLE;
      end
      thm_pkg::ST_RESP: begin
        s_d.rsp_valid = 1'b1;
        s_d.rsp_last  = 1'b1;
        s_d.rsp_data  = 16'h0000;
        s_d.rsp_exc   = s_q.exc;
        s_d.st        = thm_pkg::ST_IDLE;
      end
      default: s_d.st = thm_pkg::ST_IDLE;
    endcase
    s_d.req_ready = s_d.st == thm_pkg::ST_IDLE;
    s_d.wr_ready  = s_d.st == thm_pkg::ST_WRITE;
    s_d.unit_run  = s_d.regs[thm_pkg::OFS_RUN][0];
    s_d.act_src   = s_d.regs[thm_pkg::OFS_ACT_SRC][1:0];
    s_d.ctrl_loc  = s_d.regs[thm_pkg::OFS_CTRL_LOC][0];
    s_d.ident     = s_d.regs[thm_pkg::OFS_IDENT][1:0];
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_q           <= '0;
      s_q.regs      <= thm_pkg::REG_RESET;
      s_q.stage     <= thm_pkg::REG_RESET;
      s_q.req_ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign req_ready_out           = s_q.req_ready;
  assign wr_ready_out            = s_q.wr_ready;
  assign rsp_valid_out           = s_q.rsp_valid;
  assign rsp_data_out            = s_q.rsp_data;
  assign rsp_last_out            = s_q.rsp_last;
  assign rsp_exc_out             = s_q.rsp_exc;
  assign unit_run_out            = s_q.unit_run;
  assign actuation_source_out    = s_q.act_src;
  assign control_location_out    = s_q.ctrl_loc;
  assign identification_mode_out = s_q.ident;
  assign setpoint_out            = {s_q.regs[thm_pkg::OFS_SETPOINT],
                                    s_q.regs[thm_pkg::OFS_SETPOINT + 1]};

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  logic acc;
  assign acc = s_q.st == thm_pkg::ST_IDLE && req_valid_in;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence seq_exc_answer(logic [7:0] code);
    ##2 (rsp_valid_out && rsp_last_out && rsp_exc_out == code);
  endsequence

  chk_unsup_func: assert property (acc && !is_wr && !is_rd |-> seq_exc_answer(8'h01))
    else $error("unsupported function not refused");
  chk_remote_write: assert property (acc && is_wr && !s_q.rem[1]
                                     |-> seq_exc_answer(8'h01))
    else $error("write outside remote mode not refused");
  chk_split_float: assert property (acc && req_func_in == thm_pkg::FC_RD_HOLD
                                    && req_rd_qty_in != 8'h00
                                    && is_hi({1'b0, req_rd_addr_in})
                                    |-> seq_exc_answer(8'h02))
    else $error("split float access not refused");
  chk_input_window: assert property (acc && req_func_in == thm_pkg::FC_RD_INPUT
                                     && req_rd_qty_in != 8'h00
                                     && req_rd_addr_in != 16'(thm_pkg::OFS_SETPOINT)
                                     |-> seq_exc_answer(8'h02))
    else $error("input read off the setpoint not refused");
  chk_range_reject: assert property (s_q.st == thm_pkg::ST_CHECK && !bank_ok(s_q.stage)
                                     |=> $stable(s_q.regs) ##1
                                     (rsp_valid_out && rsp_exc_out == 8'h03))
    else $error("out of range write not refused");
  chk_bank_atomic: assert property (!$stable(s_q.regs)
                                    |-> $past(s_q.st) == thm_pkg::ST_CHECK)
    else $error("bank changed outside check");
  chk_single_write: assert property (acc && req_func_in == thm_pkg::FC_WR_SINGLE
                                     && s_q.rem[1] && span_ok(req_wr_addr_in, 8'h01)
                                     |=> wr_ready_out && s_q.cnt == 8'h01)
    else $error("single write not one word");
  chk_rw_order: assert property (s_q.st == thm_pkg::ST_CHECK && bank_ok(s_q.stage)
                                 && s_q.func == thm_pkg::FC_RD_WR
                                 |=> s_q.st == thm_pkg::ST_READ ##1 rsp_valid_out)
    else $error("read of combined transfer not after write");
  chk_read_burst: assert property (rsp_valid_out && !rsp_last_out
                                   |=> rsp_valid_out && rsp_exc_out == 8'h00)
    else $error("read burst broken");
  chk_run_follow: assert property (##1 unit_run_out == s_q.regs[thm_pkg::OFS_RUN][0]
                                   && $changed(unit_run_out)
                                   |-> $past(s_q.st) == thm_pkg::ST_CHECK)
    else $error("run output moved without a write");

endmodule : thm_holding_regs

/* thm_client_model.sv */
// modbus client model that drives requests into the holding-register bank
`timescale 1ns/1ps
module thm_client_model (
  // clock
  input  wire logic        clk_in,
  // request
  output logic             req_valid_out,
  output logic [7:0]       req_func_out,
  output logic [15:0]      req_rd_addr_out,
  output logic [7:0]       req_rd_qty_out,
  output logic [15:0]      req_wr_addr_out,
  output logic [7:0]       req_wr_qty_out,
  input  wire logic        req_ready_in,
  // write words
  output logic             wr_valid_out,
  output logic [15:0]      wr_data_out,
  input  wire logic        wr_ready_in,
  // answer
  input  wire logic        rsp_valid_in,
  input  wire logic [15:0] rsp_data_in,
  input  wire logic        rsp_last_in,
  input  wire logic [7:0]  rsp_exc_in
);
  logic [15:0] rsp_q [$];
  logic [7:0]  exc_q;
  logic        done_q;

  initial begin
    {req_valid_out, req_func_out, req_rd_addr_out, req_rd_qty_out} = '0;
    {req_wr_addr_out, req_wr_qty_out, wr_valid_out, wr_data_out} = '0;
    exc_q = 8'h00;
    done_q = 1'b0;
  end

  // --------------------------------------------------------------------
  // answer collection, one word per valid cycle
  // --------------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rsp_valid_in === 1'b1) begin
      rsp_q.push_back(rsp_data_in);
      exc_q = rsp_exc_in;
      if (rsp_last_in === 1'b1) begin
        done_q = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // one transaction: request, write words, wait for the last answer word
  // --------------------------------------------------------------------
  task automatic transact(input logic [7:0] func, input logic [15:0] ra, input logic [7:0] rq,
                          input logic [15:0] wa, input logic [7:0] wq, input logic [31:0] val,
                          input int nw);
    int i;
    int n;
    rsp_q.delete();
    done_q = 1'b0;
    exc_q = 8'hff;
    @(negedge clk_in);
    req_valid_out = 1'b1;
    {req_func_out, req_rd_addr_out, req_rd_qty_out} = {func, ra, rq};
    {req_wr_addr_out, req_wr_qty_out} = {wa, wq};
    n = 0;
    @(posedge clk_in);
    while (req_ready_in !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_in);
    end
    @(negedge clk_in);
    req_valid_out = 1'b0;
    // released function and address lines show the inverse so stale values never look valid
    req_func_out = ~req_func_out;
    req_rd_addr_out = ~req_rd_addr_out;
    req_wr_addr_out = ~req_wr_addr_out;
    for (i = 0; i < nw && done_q !== 1'b1 && n < 50; i++) begin
      wr_valid_out = 1'b1;
      // multi-register values go high half first, on one transaction
      wr_data_out = (nw == 2 && i == 0) ? val[31:16] : val[15:0];
      n = 0;
      @(posedge clk_in);
      while (wr_ready_in !== 1'b1 && rsp_valid_in !== 1'b1 && n < 50) begin
        n++;
        @(posedge clk_in);
      end
      if (wr_ready_in !== 1'b1) begin
        n = 50;
      end
      @(negedge clk_in);
    end
    wr_valid_out = 1'b0;
    wr_data_out = ~wr_data_out;
    n = 0;
    while (done_q !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_in);
    end
  endtask : transact
endmodule : thm_client_model

/* tb_top.sv */
// self-checking testbench for the thermostat holding-register bank
`timescale 1ns/1ps
module tb_top;
  logic               clk_in;
  logic               arst_n_in;
  logic               remote_mode_in;
  logic               req_valid, req_ready, wr_valid, wr_ready, rsp_valid, rsp_last;
  logic [7:0]         req_func, req_rd_qty, req_wr_qty, rsp_exc;
  logic [15:0]        req_rd_addr, req_wr_addr, wr_data, rsp_data;
  logic               unit_run, ctrl_loc;
  logic [1:0]         act_src, ident_mode;
  logic [31:0]        setpoint;
  thm_pkg::thm_bank_t shadow;
  int                 error_cnt;
  int                 total_checks;
  int                 k;
  logic [39:0] stab [22] = '{40'h0000_0001_00, 40'h0000_0000_00, 40'h0001_0001_00,
    40'h0001_0002_00, 40'h0001_0003_03, 40'h000a_0001_00, 40'h000a_0002_03, 40'h000b_0001_00,
    40'h000b_0002_00, 40'h000b_0003_03, 40'h000b_0000_00, 40'h000e_0002_03, 40'h000e_270f_00,
    40'h000e_2710_03, 40'h000f_03e7_00, 40'h000f_03e8_03, 40'h0013_0003_00, 40'h0014_03e8_03,
    40'h000c_0001_02, 40'h0009_0001_02, 40'h0019_0001_02, 40'h0000_0001_00};
  logic [55:0] ftab [12] = '{56'h000c_4120_0000_00, 56'h000c_42c8_0000_03,
    56'h000c_3dcc_cccd_00, 56'h0011_42c7_cccd_00, 56'h0011_3dcc_cccc_03,
    56'h0015_4000_0000_00, 56'h0015_bf80_0000_03, 56'h0017_40a0_0000_00,
    56'h0017_40b0_0000_03, 56'h0017_0000_0000_00, 56'h000d_4000_0000_02,
    56'h0002_4200_0000_00};

  thm_holding_regs DUT (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .remote_mode_in(remote_mode_in),
    .req_valid_in(req_valid), .req_func_in(req_func), .req_rd_addr_in(req_rd_addr),
    .req_rd_qty_in(req_rd_qty), .req_wr_addr_in(req_wr_addr), .req_wr_qty_in(req_wr_qty),
    .req_ready_out(req_ready), .wr_valid_in(wr_valid), .wr_data_in(wr_data),
    .wr_ready_out(wr_ready), .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data),
    .rsp_last_out(rsp_last), .rsp_exc_out(rsp_exc), .unit_run_out(unit_run),
    .actuation_source_out(act_src), .control_location_out(ctrl_loc),
    .identification_mode_out(ident_mode), .setpoint_out(setpoint));

  thm_client_model client (
    .clk_in(clk_in), .req_valid_out(req_valid), .req_func_out(req_func),
    .req_rd_addr_out(req_rd_addr), .req_rd_qty_out(req_rd_qty), .req_wr_addr_out(req_wr_addr),
    .req_wr_qty_out(req_wr_qty), .req_ready_in(req_ready), .wr_valid_out(wr_valid),
    .wr_data_out(wr_data), .wr_ready_in(wr_ready), .rsp_valid_in(rsp_valid),
    .rsp_data_in(rsp_data), .rsp_last_in(rsp_last), .rsp_exc_in(rsp_exc));

  // --------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // shadow only moves on an accepted write, so refused writes must leave it
  task automatic op(input logic [7:0] fc, input logic [15:0] ra, input logic [7:0] rq,
                    input logic [15:0] wa, input logic [31:0] v, input int nw,
                    input logic [7:0] exc);
    int i;
    client.transact(fc, ra, rq, wa, nw[7:0], v, nw);
    check(client.exc_q, exc);
    if (exc === 8'h00 && nw == 2) {shadow[wa], shadow[wa + 16'h0001]} = v;
    if (exc === 8'h00 && nw == 1) shadow[wa] = v[15:0];
    if (exc === 8'h00 && rq != 8'h00) begin
      check(client.rsp_q.size(), rq);
      for (i = 0; i < rq; i++) begin
        check(client.rsp_q[i], shadow[ra + i]);
      end
    end
    check(unit_run, shadow[0][0]);
    check(act_src, shadow[1][1:0]);
    check(ctrl_loc, shadow[10][0]);
    check(ident_mode, shadow[11][1:0]);
    check(setpoint, {shadow[2], shadow[3]});
  endtask : op

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    results();
  end

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    error_cnt = 0;
    total_checks = 0;
    arst_n_in = 1'b0;
    remote_mode_in = 1'b0;
    shadow = thm_pkg::REG_RESET;
    repeat (5) @(negedge clk_in);
    arst_n_in = 1'b1;
    op(8'h03, 16'h0000, 8'h08, 16'h0000, 32'h0000_0000, 0, 8'h00);
    op(8'h06, 16'h0000, 8'h00, 16'h0000, 32'h0000_0001, 1, 8'h01);
    op(8'h05, 16'h0000, 8'h01, 16'h0000, 32'h0000_0000, 0, 8'h01);
    op(8'h03, 16'h0000, 8'h00, 16'h0000, 32'h0000_0000, 0, 8'h03);
    op(8'h03, 16'h0008, 8'h01, 16'h0000, 32'h0000_0000, 0, 8'h02);
    $display("test reset and refusals done");
    remote_mode_in = 1'b1;
    repeat (4) @(negedge clk_in);
    for (k = 0; k < 22; k++) begin
      op(8'h06, 16'h0000, 8'h00, stab[k][39:24], {16'h0000, stab[k][23:8]}, 1, stab[k][7:0]);
    end
    $display("test single writes done");
    // a multiple write answers with one word only, so read the float back apart
    for (k = 0; k < 12; k++) begin
      op(8'h10, 16'h0000, 8'h00, ftab[k][55:40], ftab[k][39:8], 2, ftab[k][7:0]);
      op(8'h03, ftab[k][55:40], 8'h02, 16'h0000, 32'h0000_0000, 0,
         {6'h00, ftab[k][7:0] == 8'h02, 1'b0});
    end
    op(8'h10, 16'h0000, 8'h00, 16'h0002, 32'h0000_4000, 1, 8'h02);
    $display("test multiple writes done");
    op(8'h17, 16'h0000, 8'h04, 16'h0002, 32'h4204_0000, 2, 8'h00);
    op(8'h04, 16'h0002, 8'h02, 16'h0000, 32'h0000_0000, 0, 8'h00);
    op(8'h04, 16'h0000, 8'h02, 16'h0000, 32'h0000_0000, 0, 8'h02);
    op(8'h03, 16'h0000, 8'h08, 16'h0000, 32'h0000_0000, 0, 8'h00);
    op(8'h03, 16'h000a, 8'h0f, 16'h0000, 32'h0000_0000, 0, 8'h00);
    $display("test combined and readback done");
    results();
  end
endmodule : tb_top
